// >>> hw/clk_ctrl.sv
// Master clock switch sequencer and system/peripheral clock gating.
// Assumes one-cycle tick pulses from each clock source, synchronous to core_clk.
//
// What this block does
// - Active prescaler adds 64 cycles of the new clock to a switch.
// - Main to low-speed finishes within 0.5 main plus 4.5 low-speed cycles.
// - To main: 2.5 main from low-speed; 3 PLL+4 slow+1 main from PLL.
// - PLL to low-speed finishes within 3 PLL plus 5 low-speed cycles.
// - Main to PLL: 0.5 main, 4 slow, lock delay, 2.5 PLL cycles.
// - Low-speed to PLL: 2.5 PLL, 5 slow, plus lock delay cycles.
// - Lock delay is the count field of the target PLL.
// - PLL to other PLL: 3 plus 1.5 new PLL cycles, 4 slow.
// - Reprogramming the selected PLL falls back, then switches back once it locks.
// - Enable bits 6 and 7 start the USB host and device clocks.
// - Enable bits 8 and 9 start programmable outputs 0 and 1.
// - Disable bit 0 stops the processor clock, entering idle.
// - Disable USB or programmable bits stop those clocks; zero does nothing.
// - System status shows one for each running clock.
// - System status resets to 0x03, peripheral status to zero.
// - Peripheral enable bits 2 to 31 start that peripheral clock.
// - Bits of unimplemented peripherals change nothing.
// - Peripheral disable bits stop that peripheral clock.
// - Peripheral status shows one for each enabled clock.
// - Unlocked first PLL falls back to low-speed, second to main.
// - Ready flag drops during source or prescaler change.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module clk_ctrl #(
  parameter logic [31:0] PERIPH_IMPL = 32'hFFFF_FFFC
) (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire clk_ctrl_pkg::tick_t   ticks,
  input  wire logic                  cpu_wake,
  output clk_ctrl_pkg::gate_t        gates,
  output clk_ctrl_pkg::mck_src_t     mck_src,
  output logic [2:0]                 mck_pres,
  output logic [1:0]                 pll_lock,
  output logic                       master_clock_ready_flag
);
  logic [31:0]            scsr_r;
  logic [31:0]            pcsr_r;
  logic [31:0]            mor_r;
  logic [31:0]            mckr_r;
  logic [31:0]            prog0_r;
  logic [31:0]            prog1_r;
  logic [31:0]            imr_r;
  logic [31:0]            icpr_r;
  logic [31:0]            pll_cfg_r [2];
  logic [1:0]             lock_r;
  logic [31:0]            rdata;
  logic [31:0]            prdata_r;
  logic                   pslverr_r;
  logic                   mapped;
  logic                   wr;
  logic [31:0]            sc_en;
  logic [31:0]            sc_dis;
  logic [31:0]            pc_en;
  logic [31:0]            pc_dis;
  clk_ctrl_pkg::mck_src_t css;
  clk_ctrl_pkg::mck_src_t tgt;
  clk_ctrl_pkg::mck_src_t src_r;
  clk_ctrl_pkg::mck_src_t to_r;
  clk_ctrl_pkg::mck_src_t from_r;
  logic [2:0]             pres_r;
  clk_ctrl_pkg::sw_state_t state_r;
  clk_ctrl_pkg::sw_state_t state_nxt;
  clk_ctrl_pkg::sw_plan_t plan_r;
  logic [7:0]             cnt_r;
  logic [7:0]             need;
  logic                   stage_tick;
  logic                   stage_done;
  logic                   to_lock;

  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // Address decode
  always_comb
  begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    case (paddr)
      clk_ctrl_pkg::OFF_SCER, clk_ctrl_pkg::OFF_SCDR, clk_ctrl_pkg::OFF_PCER,
      clk_ctrl_pkg::OFF_PCDR, clk_ctrl_pkg::OFF_IER, clk_ctrl_pkg::OFF_IDR,
      clk_ctrl_pkg::OFF_MCFR: rdata = 32'h0000_0000;
      clk_ctrl_pkg::OFF_SCSR:  rdata = scsr_r;
      clk_ctrl_pkg::OFF_PCSR:  rdata = pcsr_r;
      clk_ctrl_pkg::OFF_MOR:   rdata = mor_r;
      clk_ctrl_pkg::OFF_FIRST_PLL:  rdata = pll_cfg_r[0];
      clk_ctrl_pkg::OFF_SECOND_PLL:  rdata = pll_cfg_r[1];
      clk_ctrl_pkg::OFF_MCKR:  rdata = mckr_r;
      clk_ctrl_pkg::OFF_PROG0: rdata = prog0_r;
      clk_ctrl_pkg::OFF_PROG1: rdata = prog1_r;
      clk_ctrl_pkg::OFF_IMR:   rdata = imr_r;
      clk_ctrl_pkg::OFF_ICPR:  rdata = icpr_r;
      clk_ctrl_pkg::OFF_SR:
      begin
        rdata[clk_ctrl_pkg::SR_LOCKA]  = lock_r[0];
        rdata[clk_ctrl_pkg::SR_LOCKB]  = lock_r[1];
        rdata[clk_ctrl_pkg::SR_MASTER_CLOCK_READY_FLAG] = master_clock_ready_flag;
      end
      default: mapped = 1'b0;
    endcase
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata_r  <= pwrite ? 32'h0000_0000 : rdata;
      pslverr_r <= !mapped;
    end
  end

  // Write-one enable and disable strobes
  assign sc_en  = (wr && paddr == clk_ctrl_pkg::OFF_SCER) ?
                  (pwdata & clk_ctrl_pkg::SC_EN_MASK) : 32'h0000_0000;
  assign sc_dis = (wr && paddr == clk_ctrl_pkg::OFF_SCDR) ?
                  (pwdata & clk_ctrl_pkg::SC_DIS_MASK) : 32'h0000_0000;
  assign pc_en  = (wr && paddr == clk_ctrl_pkg::OFF_PCER) ?
                  (pwdata & PERIPH_IMPL) : 32'h0000_0000;
  assign pc_dis = (wr && paddr == clk_ctrl_pkg::OFF_PCDR) ?
                  (pwdata & PERIPH_IMPL) : 32'h0000_0000;

  // System clock status; the wake event re-enables the processor clock
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      scsr_r <= clk_ctrl_pkg::SCSR_RST;
    else
      scsr_r <= (scsr_r & ~sc_dis) | sc_en |
                {31'h0000_0000, cpu_wake};
  end

  // Peripheral clock status
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      pcsr_r <= clk_ctrl_pkg::PCSR_RST;
    else
      pcsr_r <= (pcsr_r & ~pc_dis) | pc_en;
  end

  assign gates.proc     = scsr_r[clk_ctrl_pkg::BIT_PROC];
  assign gates.usb_host = scsr_r[clk_ctrl_pkg::BIT_USB_HOST];
  assign gates.usb_dev  = scsr_r[clk_ctrl_pkg::BIT_USB_DEV];
  assign gates.prog     = scsr_r[clk_ctrl_pkg::BIT_PROG1:clk_ctrl_pkg::BIT_PROG0];
  assign gates.periph   = pcsr_r;

  // Plain read/write configuration registers
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      mor_r   <= clk_ctrl_pkg::ZERO_RST;
      mckr_r  <= clk_ctrl_pkg::ZERO_RST;
      prog0_r <= clk_ctrl_pkg::ZERO_RST;
      prog1_r <= clk_ctrl_pkg::ZERO_RST;
      icpr_r  <= clk_ctrl_pkg::ZERO_RST;
    end
    else if (wr)
    begin
      case (paddr)
        clk_ctrl_pkg::OFF_MOR:   mor_r   <= pwdata;
        clk_ctrl_pkg::OFF_MCKR:  mckr_r  <= pwdata;
        clk_ctrl_pkg::OFF_PROG0: prog0_r <= pwdata;
        clk_ctrl_pkg::OFF_PROG1: prog1_r <= pwdata;
        clk_ctrl_pkg::OFF_ICPR:  icpr_r  <= pwdata;
        default: ;
      endcase
    end
  end

  // Interrupt mask bookkeeping only
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      imr_r <= clk_ctrl_pkg::ZERO_RST;
    else if (wr && paddr == clk_ctrl_pkg::OFF_IER)
      imr_r <= imr_r | pwdata;
    else if (wr && paddr == clk_ctrl_pkg::OFF_IDR)
      imr_r <= imr_r & ~pwdata;
  end

  // Per-PLL configuration and lock delay counter
  for (genvar g = 0; g < 2; g++)
  begin : g_pll
    logic [clk_ctrl_pkg::LOCK_CNT_W-1:0] lcnt_r;
    logic                                pend_r;
    logic                                wr_cfg;
    assign wr_cfg = wr && paddr == (g == 0 ? clk_ctrl_pkg::OFF_FIRST_PLL
                                           : clk_ctrl_pkg::OFF_SECOND_PLL);
    always_ff @(posedge core_clk)
    begin
      if (sys_rst)
      begin
        pll_cfg_r[g] <= clk_ctrl_pkg::PLL_CFG_RST;
        lcnt_r       <= '0;
        pend_r       <= 1'b0;
        lock_r[g]    <= 1'b0;
      end
      else if (wr_cfg)
      begin
        pll_cfg_r[g] <= pwdata;
        lcnt_r       <= pwdata[clk_ctrl_pkg::LOCK_CNT_LO +: clk_ctrl_pkg::LOCK_CNT_W];
        pend_r       <= 1'b1;
        lock_r[g]    <= 1'b0;
      end
      else if (pend_r && lcnt_r == '0)
      begin
        pend_r    <= 1'b0;
        lock_r[g] <= 1'b1;
      end
      else if (pend_r && ticks.slow)
        lcnt_r <= lcnt_r - 1'b1;
    end
  end
  assign pll_lock = lock_r;

  // Effective source with fallback while a selected PLL is unlocked
  assign css = clk_ctrl_pkg::mck_src_t'(mckr_r[clk_ctrl_pkg::CSS_LO +: 2]);
  always_comb
  begin
    tgt = css;
    if (css == clk_ctrl_pkg::SRC_FIRST_PLL && !lock_r[0])
      tgt = clk_ctrl_pkg::SRC_SLOW;
    else if (css == clk_ctrl_pkg::SRC_SECOND_PLL && !lock_r[1])
      tgt = clk_ctrl_pkg::SRC_MAIN;
  end

  // Switch plan per source pair
  function automatic clk_ctrl_pkg::sw_plan_t plan_of(clk_ctrl_pkg::mck_src_t f,
                                                      clk_ctrl_pkg::mck_src_t t);
    clk_ctrl_pkg::sw_plan_t p;
    logic f_pll;
    p = '0;
    f_pll = f[1];
    case (t)
      clk_ctrl_pkg::SRC_MAIN:
      begin
        if (f_pll)
        begin
          p.old_n  = clk_ctrl_pkg::N_P2M_OLD;
          p.slow_n = clk_ctrl_pkg::N_P2M_SLOW;
          p.new_n  = clk_ctrl_pkg::N_P2M_NEW;
        end
        else
          p.new_n = clk_ctrl_pkg::N_S2M_NEW;
      end
      clk_ctrl_pkg::SRC_SLOW:
      begin
        if (f_pll)
        begin
          p.old_n  = clk_ctrl_pkg::N_P2S_OLD;
          p.slow_n = clk_ctrl_pkg::N_P2S_SLOW;
        end
        else
          p.slow_n = clk_ctrl_pkg::N_M2S_SLOW;
      end
      default:
      begin
        p.new_n    = clk_ctrl_pkg::N_TOP_NEW;
        p.use_lock = 1'b1;
        if (f == clk_ctrl_pkg::SRC_MAIN)
          p.slow_n = clk_ctrl_pkg::N_M2P_SLOW;
        else if (f == clk_ctrl_pkg::SRC_SLOW)
          p.slow_n = clk_ctrl_pkg::N_S2P_SLOW;
        else if (f == t)
          p.slow_n = clk_ctrl_pkg::N_PP_SLOW;
        else
        begin
          p.slow_n   = clk_ctrl_pkg::N_PP_SLOW;
          p.new_n    = clk_ctrl_pkg::N_X2P_NEW;
          p.use_lock = 1'b0;
        end
      end
    endcase
    return p;
  endfunction

  function automatic logic tick_of(clk_ctrl_pkg::mck_src_t s, clk_ctrl_pkg::tick_t t);
    case (s)
      clk_ctrl_pkg::SRC_SLOW: return t.slow;
      clk_ctrl_pkg::SRC_MAIN: return t.main;
      clk_ctrl_pkg::SRC_FIRST_PLL: return t.pll_a;
      default:                return t.pll_b;
    endcase
  endfunction

  // Stage length and tick source
  assign to_lock = to_r == clk_ctrl_pkg::SRC_FIRST_PLL ? lock_r[0] : lock_r[1];
  always_comb
  begin
    need       = 8'h00;
    stage_tick = 1'b0;
    case (state_r)
      clk_ctrl_pkg::SW_OLD:
      begin
        need       = plan_r.old_n;
        stage_tick = tick_of(from_r, ticks);
      end
      clk_ctrl_pkg::SW_SLOW:
      begin
        need       = plan_r.slow_n;
        stage_tick = ticks.slow;
      end
      clk_ctrl_pkg::SW_NEW:
      begin
        need       = plan_r.new_n;
        stage_tick = tick_of(to_r, ticks);
      end
      clk_ctrl_pkg::SW_PRES:
      begin
        need       = (mckr_r[clk_ctrl_pkg::PRES_LO +: 3] != 3'b000) ?
                     clk_ctrl_pkg::N_PRES : 8'h00;
        stage_tick = tick_of(src_r, ticks);
      end
      default: ;
    endcase
  end
  assign stage_done = cnt_r >= need;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      clk_ctrl_pkg::SW_IDLE:
        if (tgt != src_r)
          state_nxt = clk_ctrl_pkg::SW_OLD;
        else if (mckr_r[clk_ctrl_pkg::PRES_LO +: 3] != pres_r)
          state_nxt = clk_ctrl_pkg::SW_PRES;
      clk_ctrl_pkg::SW_OLD:
        if (stage_done)
          state_nxt = clk_ctrl_pkg::SW_SLOW;
      clk_ctrl_pkg::SW_SLOW:
        if (stage_done)
          state_nxt = clk_ctrl_pkg::SW_LOCK;
      clk_ctrl_pkg::SW_LOCK:
        if (!plan_r.use_lock || to_lock)
          state_nxt = clk_ctrl_pkg::SW_NEW;
      clk_ctrl_pkg::SW_NEW:
        if (stage_done)
          state_nxt = clk_ctrl_pkg::SW_PRES;
      clk_ctrl_pkg::SW_PRES:
        if (stage_done)
          state_nxt = clk_ctrl_pkg::SW_IDLE;
      default:
        state_nxt = clk_ctrl_pkg::SW_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_r <= clk_ctrl_pkg::SW_IDLE;
      cnt_r   <= 8'h00;
      src_r   <= clk_ctrl_pkg::SRC_SLOW;
      from_r  <= clk_ctrl_pkg::SRC_SLOW;
      to_r    <= clk_ctrl_pkg::SRC_SLOW;
      pres_r  <= 3'b000;
      plan_r  <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_nxt != state_r)
        cnt_r <= 8'h00;
      else if (stage_tick && !stage_done)
        cnt_r <= cnt_r + 8'h01;
      if (state_r == clk_ctrl_pkg::SW_IDLE && tgt != src_r)
      begin
        from_r <= src_r;
        to_r   <= tgt;
        plan_r <= plan_of(src_r, tgt);
      end
      if (state_r == clk_ctrl_pkg::SW_NEW && stage_done)
        src_r <= to_r;
      if (state_r == clk_ctrl_pkg::SW_PRES && stage_done)
        pres_r <= mckr_r[clk_ctrl_pkg::PRES_LO +: 3];
    end
  end

  assign mck_src  = src_r;
  assign mck_pres = pres_r;
  assign master_clock_ready_flag = state_r == clk_ctrl_pkg::SW_IDLE && tgt == src_r &&
                                   mckr_r[clk_ctrl_pkg::PRES_LO +: 3] == pres_r;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_mckr_write;
    wr && paddr == clk_ctrl_pkg::OFF_MCKR &&
      pwdata[1:0] != mckr_r[1:0] && !(pwdata[1] && !lock_r[pwdata[0]]);
  endsequence

  a_sys_enable: assert property (sc_en[clk_ctrl_pkg::BIT_USB_HOST] |=>
    gates.usb_host) else $error("usb host clock not enabled");
  a_prog_enable: assert property (sc_en[clk_ctrl_pkg::BIT_PROG1] |=>
    gates.prog[1]) else $error("prog output one not enabled");
  a_proc_idle: assert property (sc_dis[clk_ctrl_pkg::BIT_PROC] && !cpu_wake |=>
    !gates.proc) else $error("processor clock still running");
  a_sys_hold: assert property (sc_en == 32'h0 && sc_dis == 32'h0 && !cpu_wake |=>
    scsr_r == $past(scsr_r)) else $error("system status changed without write");
  a_periph_gate: assert property (pc_en[5] |=> pcsr_r[5])
    else $error("peripheral gate not enabled");
  a_periph_off: assert property (pc_dis[5] && !pc_en[5] |=> !pcsr_r[5])
    else $error("peripheral gate not disabled");
  a_unimpl_quiet: assert property ((pcsr_r & ~PERIPH_IMPL) == 32'h0)
    else $error("unimplemented peripheral bit set");
  a_reset_values: assert property ($fell(sys_rst) |->
    scsr_r == clk_ctrl_pkg::SCSR_RST && pcsr_r == 32'h0) else $error("bad reset value");
  a_ready_drop: assert property (s_mckr_write |=> !master_clock_ready_flag)
    else $error("ready flag did not drop");
  a_pres_extra: assert property (state_r == clk_ctrl_pkg::SW_PRES &&
    state_nxt != clk_ctrl_pkg::SW_PRES && pres_r != mckr_r[4:2] && mckr_r[4:2] != 3'b000
    |-> cnt_r == clk_ctrl_pkg::N_PRES) else $error("prescaler stage too short");
  a_lock_wait: assert property (state_r == clk_ctrl_pkg::SW_LOCK && plan_r.use_lock &&
    !to_lock |=> state_r == clk_ctrl_pkg::SW_LOCK) else $error("left lock stage early");
  a_fallback_src: assert property (css == clk_ctrl_pkg::SRC_FIRST_PLL && !lock_r[0] &&
    state_r == clk_ctrl_pkg::SW_IDLE && master_clock_ready_flag |->
    src_r != clk_ctrl_pkg::SRC_FIRST_PLL ##0
    src_r == clk_ctrl_pkg::SRC_SLOW) else $error("no fallback to low-speed");
  a_slow_stage: assert property (state_r == clk_ctrl_pkg::SW_SLOW &&
    state_nxt == clk_ctrl_pkg::SW_LOCK |-> cnt_r == plan_r.slow_n)
    else $error("slow stage length wrong");
endmodule

// >>> hw/clk_ctrl_pkg.sv
// Constants, field layouts and carrier types for the clock controller.
// Assumes a 32-bit APB slave with byte offsets on an 8-bit address.
package clk_ctrl_pkg;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_SCER  = 8'h00;
  localparam logic [7:0] OFF_SCDR  = 8'h04;
  localparam logic [7:0] OFF_SCSR  = 8'h08;
  localparam logic [7:0] OFF_PCER  = 8'h10;
  localparam logic [7:0] OFF_PCDR  = 8'h14;
  localparam logic [7:0] OFF_PCSR  = 8'h18;
  localparam logic [7:0] OFF_MOR   = 8'h20;
  localparam logic [7:0] OFF_MCFR  = 8'h24;
  localparam logic [7:0] OFF_FIRST_PLL  = 8'h28;
  localparam logic [7:0] OFF_SECOND_PLL  = 8'h2C;
  localparam logic [7:0] OFF_MCKR  = 8'h30;
  localparam logic [7:0] OFF_PROG0 = 8'h40;
  localparam logic [7:0] OFF_PROG1 = 8'h44;
  localparam logic [7:0] OFF_IER   = 8'h60;
  localparam logic [7:0] OFF_IDR   = 8'h64;
  localparam logic [7:0] OFF_SR    = 8'h68;
  localparam logic [7:0] OFF_IMR   = 8'h6C;
  localparam logic [7:0] OFF_ICPR  = 8'h80;
  // System clock bit positions
  localparam int BIT_PROC     = 0;
  localparam int BIT_USB_HOST = 6;
  localparam int BIT_USB_DEV  = 7;
  localparam int BIT_PROG0    = 8;
  localparam int BIT_PROG1    = 9;
  localparam logic [31:0] SC_EN_MASK  = 32'h0000_03C0;
  localparam logic [31:0] SC_DIS_MASK = 32'h0000_03C1;
  // Reset values
  localparam logic [31:0] SCSR_RST    = 32'h0000_0003;
  localparam logic [31:0] PCSR_RST    = 32'h0000_0000;
  localparam logic [31:0] PLL_CFG_RST = 32'h0000_3F00;
  localparam logic [31:0] ZERO_RST    = 32'h0000_0000;
  // Field positions
  localparam int LOCK_CNT_LO = 8;
  localparam int LOCK_CNT_W  = 6;
  localparam int CSS_LO      = 0;
  localparam int PRES_LO     = 2;
  localparam int SR_LOCKA    = 1;
  localparam int SR_LOCKB    = 2;
  localparam int SR_MASTER_CLOCK_READY_FLAG   = 3;
  // Switching tick counts
  localparam logic [7:0] N_PRES        = 8'h40;
  localparam logic [7:0] N_S2M_NEW     = 8'h02;
  localparam logic [7:0] N_P2M_OLD     = 8'h03;
  localparam logic [7:0] N_P2M_SLOW    = 8'h04;
  localparam logic [7:0] N_P2M_NEW     = 8'h01;
  localparam logic [7:0] N_M2S_SLOW    = 8'h04;
  localparam logic [7:0] N_P2S_OLD     = 8'h03;
  localparam logic [7:0] N_P2S_SLOW    = 8'h05;
  localparam logic [7:0] N_M2P_SLOW    = 8'h04;
  localparam logic [7:0] N_S2P_SLOW    = 8'h05;
  localparam logic [7:0] N_PP_SLOW     = 8'h04;
  localparam logic [7:0] N_TOP_NEW     = 8'h02;
  localparam logic [7:0] N_X2P_NEW     = 8'h04;

  typedef enum logic [1:0] {
    SRC_SLOW = 2'b00,
    SRC_MAIN = 2'b01,
    SRC_FIRST_PLL = 2'b10,
    SRC_SECOND_PLL = 2'b11
  } mck_src_t;

  typedef enum logic [2:0] {
    SW_IDLE = 3'b000,
    SW_OLD  = 3'b001,
    SW_SLOW = 3'b010,
    SW_LOCK = 3'b011,
    SW_NEW  = 3'b100,
    SW_PRES = 3'b101
  } sw_state_t;

  typedef struct packed {
    logic slow;
    logic main;
    logic pll_a;
    logic pll_b;
  } tick_t;

  typedef struct packed {
    logic        proc;
    logic        usb_host;
    logic        usb_dev;
    logic [1:0]  prog;
    logic [31:0] periph;
  } gate_t;

  typedef struct packed {
    logic [7:0] old_n;
    logic [7:0] slow_n;
    logic [7:0] new_n;
    logic       use_lock;
  } sw_plan_t;
endpackage

// >>> tb/clk_ctrl_tb.sv
// Self-checking bench for the clock controller: APB access, gating, switching.
// Assumes the design's own assertions and a zero-wait APB slave.
`timescale 1ns/1ps
module clk_ctrl_tb;
  logic                    core_clk;
  logic                    sys_rst;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [7:0]              paddr;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  clk_ctrl_pkg::tick_t     ticks;
  logic                    cpu_wake;
  clk_ctrl_pkg::gate_t     gates;
  clk_ctrl_pkg::mck_src_t  mck_src;
  logic [2:0]              mck_pres;
  logic [1:0]              pll_lock;
  logic                    master_clock_ready_flag;
  logic [2:0]              tcnt;
  int                      num_errors;
  int                      n_checks;

  clk_ctrl dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ticks(ticks), .cpu_wake(cpu_wake), .gates(gates),
    .mck_src(mck_src), .mck_pres(mck_pres), .pll_lock(pll_lock),
    .master_clock_ready_flag(master_clock_ready_flag));

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  // Slow tick every 8 cycles, main every 2, both PLLs every cycle
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      tcnt <= 3'h0;
      ticks <= '0;
    end
    else
    begin
      tcnt <= tcnt + 3'h1;
      ticks <= '{slow: (tcnt == 3'h7), main: tcnt[0], pll_a: 1'b1, pll_b: 1'b1};
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
  endtask

  task automatic t_reset();
    rd_chk("system_status", clk_ctrl_pkg::OFF_SCSR, 32'h0000_0003);
    rd_chk("periph_status", clk_ctrl_pkg::OFF_PCSR, 32'h0000_0000);
    rd_chk("pll_a_config", clk_ctrl_pkg::OFF_FIRST_PLL, 32'h0000_3F00);
    $display("test reset done");
  endtask

  task automatic t_sys();
    wr(clk_ctrl_pkg::OFF_SCER, 32'h0000_03C0);
    rd_chk("system_status", clk_ctrl_pkg::OFF_SCSR, 32'h0000_03C3);
    chk("usb_host_gate", 32'h1, {31'h0, gates.usb_host});
    chk("prog_gate", 32'h3, {30'h0, gates.prog});
    wr(clk_ctrl_pkg::OFF_SCER, 32'h0000_0000);
    wr(clk_ctrl_pkg::OFF_SCDR, 32'h0000_00C1);
    rd_chk("system_status", clk_ctrl_pkg::OFF_SCSR, 32'h0000_0302);
    chk("proc_gate", 32'h0, {31'h0, gates.proc});
    wr(clk_ctrl_pkg::OFF_SCDR, 32'h0000_0000);
    wr(clk_ctrl_pkg::OFF_SCDR, 32'h0000_0300);
    @(posedge core_clk);
    cpu_wake <= 1'b1;
    @(posedge core_clk);
    cpu_wake <= 1'b0;
    rd_chk("system_status", clk_ctrl_pkg::OFF_SCSR, 32'h0000_0003);
    $display("test system clocks done");
  endtask

  task automatic t_per();
    logic [31:0] r;
    logic        e;
    wr(clk_ctrl_pkg::OFF_PCER, 32'hFFFF_FFFF);
    rd_chk("periph_status", clk_ctrl_pkg::OFF_PCSR, 32'hFFFF_FFFC);
    wr(clk_ctrl_pkg::OFF_PCDR, 32'h0000_0010);
    wr(clk_ctrl_pkg::OFF_PCER, 32'h0000_0000);
    rd_chk("periph_status", clk_ctrl_pkg::OFF_PCSR, 32'hFFFF_FFEC);
    chk("periph_gates", 32'hFFFF_FFEC, gates.periph);
    wr(clk_ctrl_pkg::OFF_PCDR, 32'hFFFF_FFFF);
    rd_chk("periph_status", clk_ctrl_pkg::OFF_PCSR, 32'h0000_0000);
    apb(1'b0, 8'h0C, 32'h0, r, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, r);
    $display("test peripheral clocks done");
  endtask

  task automatic sw(input logic [31:0] v, input int lo, input int hi);
    int n;
    wr(clk_ctrl_pkg::OFF_MCKR, v);
    @(posedge core_clk);
    chk("ready_low", 32'h0, {31'h0, master_clock_ready_flag});
    n = 1;
    while (master_clock_ready_flag !== 1'b1 && n < 400)
    begin
      @(posedge core_clk);
      n++;
    end
    chk("switch_cycles_in_bound", 32'h1, {31'h0, (n >= lo && n <= hi)});
    chk("mck_src", {30'h0, v[1:0]}, {30'h0, mck_src});
  endtask

  task automatic t_switch();
    int n;
    wr(clk_ctrl_pkg::OFF_FIRST_PLL, 32'h0000_0200);
    wr(clk_ctrl_pkg::OFF_SECOND_PLL, 32'h0000_0100);
    n = 0;
    while (pll_lock !== 2'b11 && n < 100)
    begin
      @(posedge core_clk);
      n++;
    end
    rd_chk("controller_status", clk_ctrl_pkg::OFF_SR, 32'h0000_000E);
    sw(32'h0000_0001, 1, 13);
    sw(32'h0000_0006, 64, 124);
    sw(32'h0000_0007, 64, 110);
    wr(clk_ctrl_pkg::OFF_SECOND_PLL, 32'h0000_1400);
    n = 0;
    while (mck_src !== clk_ctrl_pkg::SRC_MAIN && n < 150)
    begin
      @(posedge core_clk);
      n++;
    end
    chk("fallback_src", {30'h0, clk_ctrl_pkg::SRC_MAIN}, {30'h0, mck_src});
    $display("test master switch done");
  endtask

  initial
  begin
    #(50 * 20000);
    num_errors++;
    stop_test();
  end

  initial
  begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cpu_wake = 1'b0;
    num_errors = 0;
    n_checks = 0;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_sys();
    t_per();
    t_switch();
    stop_test();
  end
endmodule
